// file: logic/isr_top.sv
// status aggregation for the instrument remote interface
// Summary of operation
// - event bits latch and ignore later changes
// - event read returns weighted sum of bits
// - readable writable masks; enabled bits ORed
// - mask reads and clear-status keep masks
// - status bit 3 questionable enabled summary
// - status bit 4 output message available
// - status bit 5 standard event summary
// - status bit 6 request service, serial poll
// - clearing event register clears its summary
// - message bit clears when buffer drained
// - clear-status clears event summaries; reads clear own
// - status mask cleared by zero or flag
// - flag zero keeps status mask through power
// - operation complete sets event bit 0
// - query errors set event bit 2
// - device faults or overload set bit 3
// - execution bit 4, syntax bit 5
// - power cycle sets event bit 7
// - queued errors set bits 2-5 only
// - overload sets bits, no queue entry
// - unused status and event bits zero
// - clear-status clears event summaries and all events, not bit 4
module isr_top (
    input  wire logic        core_clk_i,
    input  wire logic        rst_b_i,        // power-up reset
    // nonvolatile image caught after power-up
    input  wire logic        nv_psc_i,       // stored power-on-clear flag
    input  wire logic [7:0]  nv_ese_i,       // stored standard event mask
    input  wire logic [7:0]  nv_sre_i,       // stored status byte mask
    // command port from the parser
    input  wire logic        cls_i,          // clear status
    input  wire logic        ese_wr_i,
    input  wire logic [7:0]  ese_data_i,
    input  wire logic        sre_wr_i,
    input  wire logic [7:0]  sre_data_i,
    input  wire logic        qen_wr_i,
    input  wire logic [15:0] qen_data_i,
    input  wire logic        qen_preset_i,   // status preset
    input  wire logic        psc_wr_i,
    input  wire logic        psc_data_i,
    input  wire logic        qry_i,          // query strobe
    input  wire logic [2:0]  qry_sel_i,      // which register
    // instrument conditions, one-cycle pulses except the msg_avail_i buffer level
    input  wire logic        opc_done_i,
    input  wire logic        qerr_empty_i,
    input  wire logic        qerr_unread_i,
    input  wire logic        qerr_full_i,
    input  wire logic        selftest_fail_i,
    input  wire logic        cal_fail_i,
    input  wire logic        ovl_volt_i,
    input  wire logic        ovl_curr_i,
    input  wire logic        ovl_ohm_i,
    input  wire logic        limit_lo_i,
    input  wire logic        limit_hi_i,
    input  wire logic        exec_err_i,
    input  wire logic        cmd_err_i,
    input  wire logic        msg_avail_i,    // output buffer not empty
    // answers
    output logic             rd_valid_o,
    output logic [15:0]      rd_data_o,
    output logic [7:0]       stb_o,          // status summary byte
    output logic             srq_o,          // service request level
    output logic             err_push_o,     // error queue entry
    output logic [7:0]       ese_o,
    output logic [7:0]       sre_o,
    output logic [15:0]      qen_o,
    output logic             psc_o
);

    isr_pkg::isr_pwr_e pwr_state;       // power-up sequencer
    isr_pkg::isr_pwr_e next_pwr_state;
    wire logic         power_up;        // first cycle after release

    wire logic [7:0]   esr_set;         // standard event conditions
    wire logic [15:0]  qev_set;         // questionable conditions
    wire logic [7:0]   esr_latch;
    wire logic [15:0]  qev_latch;
    wire logic         esr_sum;
    wire logic         qev_sum;
    wire logic         esr_clr;
    wire logic         qev_clr;
    wire logic         ovl_any;
    wire logic         err_any;
    wire logic [7:0]   stb_comb;        // status byte before register
    wire logic         rqs;
    wire logic [15:0]  rd_mux;
    wire logic [7:0]   ese_restore;
    wire logic [7:0]   sre_restore;
    logic              psc;             // power-on-clear flag

    // sequencer: one load cycle after reset, then run for good
    always_comb begin
        case (pwr_state)
            isr_pkg::PWR_LOAD: next_pwr_state = isr_pkg::PWR_RUN;
            isr_pkg::PWR_RUN:  next_pwr_state = isr_pkg::PWR_RUN;
            default:           next_pwr_state = isr_pkg::PWR_RUN;
        endcase
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pwr_state <= isr_pkg::PWR_LOAD;
        end else begin
            pwr_state <= next_pwr_state;
        end
    end

    assign power_up = (pwr_state == isr_pkg::PWR_LOAD);

    // flag is caught after release, never under reset
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            psc <= 1'b0;
        end else if (power_up) begin
            psc <= nv_psc_i;
        end else if (psc_wr_i) begin
            psc <= psc_data_i;
        end
    end

    assign psc_o = psc;

    // overloads feed the event bits but never the error queue
    assign ovl_any = ovl_volt_i | ovl_curr_i | ovl_ohm_i;
    assign err_any = qerr_empty_i | qerr_unread_i | qerr_full_i
                   | selftest_fail_i | cal_fail_i | exec_err_i | cmd_err_i;

    // standard event condition map
    assign esr_set[isr_pkg::ESR_OPC]  = opc_done_i;
    assign esr_set[isr_pkg::ESR_UNU1] = 1'b0;
    assign esr_set[isr_pkg::ESR_QYE]  = qerr_empty_i | qerr_unread_i | qerr_full_i;
    assign esr_set[isr_pkg::ESR_DDE]  = selftest_fail_i | cal_fail_i | ovl_any;
    assign esr_set[isr_pkg::ESR_EXE]  = exec_err_i;
    assign esr_set[isr_pkg::ESR_CME]  = cmd_err_i;
    assign esr_set[isr_pkg::ESR_UNU6] = 1'b0;
    assign esr_set[isr_pkg::ESR_PON]  = power_up;

    // questionable condition map; other bits never set
    assign qev_set = (16'h0001 << isr_pkg::QEV_VOLT) & {16{ovl_volt_i}}
                   | (16'h0001 << isr_pkg::QEV_CURR) & {16{ovl_curr_i}}
                   | (16'h0001 << isr_pkg::QEV_OHM)  & {16{ovl_ohm_i}}
                   | (16'h0001 << isr_pkg::QEV_LLO)  & {16{limit_lo_i}}
                   | (16'h0001 << isr_pkg::QEV_LHI)  & {16{limit_hi_i}};

    // a read clears only its own latch; clear-status clears both
    assign esr_clr = cls_i | (qry_i && qry_sel_i == isr_pkg::QRY_ESR);
    assign qev_clr = cls_i | (qry_i && qry_sel_i == isr_pkg::QRY_QEV);

    // standard event latch
    isr_evt_latch #(
        .WIDTH (isr_pkg::ESR_W)
    ) u_esr (
        .core_clk_i (core_clk_i),
        .rst_b_i    (rst_b_i),
        .set_i      (esr_set),
        .clr_i      (esr_clr),
        .mask_i     (ese_o),
        .latch_o    (esr_latch),
        .summary_o  (esr_sum)
    );

    // questionable-data latch
    isr_evt_latch #(
        .WIDTH (isr_pkg::QEV_W)
    ) u_qev (
        .core_clk_i (core_clk_i),
        .rst_b_i    (rst_b_i),
        .set_i      (qev_set),
        .clr_i      (qev_clr),
        .mask_i     (qen_o),
        .latch_o    (qev_latch),
        .summary_o  (qev_sum)
    );

    // masks survive power-up only when the stored flag is zero
    assign ese_restore = nv_psc_i ? isr_pkg::RST_MASK8 : nv_ese_i;
    assign sre_restore = nv_psc_i ? isr_pkg::RST_MASK8 : nv_sre_i;

    // standard event enable mask
    isr_mask_reg #(
        .WIDTH (8)
    ) u_ese (
        .core_clk_i    (core_clk_i),
        .rst_b_i       (rst_b_i),
        .restore_i     (power_up),
        .restore_val_i (ese_restore),
        .wr_i          (ese_wr_i),
        .wr_data_i     (ese_data_i),
        .preset_i      (1'b0),
        .mask_o        (ese_o)
    );

    // status byte enable mask, a write of zero clears it
    isr_mask_reg #(
        .WIDTH (8)
    ) u_sre (
        .core_clk_i    (core_clk_i),
        .rst_b_i       (rst_b_i),
        .restore_i     (power_up),
        .restore_val_i (sre_restore),
        .wr_i          (sre_wr_i),
        .wr_data_i     (sre_data_i),
        .preset_i      (1'b0),
        .mask_o        (sre_o)
    );

    // questionable enable mask is always cleared at power-up
    isr_mask_reg #(
        .WIDTH (16)
    ) u_qen (
        .core_clk_i    (core_clk_i),
        .rst_b_i       (rst_b_i),
        .restore_i     (power_up),
        .restore_val_i (isr_pkg::RST_MASK16),
        .wr_i          (qen_wr_i),
        .wr_data_i     (qen_data_i),
        .preset_i      (qen_preset_i),
        .mask_o        (qen_o)
    );

    // summary bits follow the latches, so clearing them clears these
    assign stb_comb[0] = 1'b0;
    assign stb_comb[1] = 1'b0;
    assign stb_comb[2] = 1'b0;
    assign stb_comb[isr_pkg::STB_QSUM] = qev_sum;
    assign stb_comb[isr_pkg::STB_MAV]  = msg_avail_i;
    assign stb_comb[isr_pkg::STB_ESUM] = esr_sum;
    assign stb_comb[isr_pkg::STB_RQS]  = rqs;
    assign stb_comb[7] = 1'b0;

    // service request level; bit 6 of the mask is ignored
    // built from the sources, not from stb_comb, so no net feeds itself
    assign rqs = |({esr_sum, msg_avail_i, qev_sum, 3'h0} & sre_o[5:0]);

    // query answer selection
    assign rd_mux = (qry_sel_i == isr_pkg::QRY_STB) ? {8'h00, stb_o} :
                    (qry_sel_i == isr_pkg::QRY_ESR) ? {8'h00, esr_latch} :
                    (qry_sel_i == isr_pkg::QRY_ESE) ? {8'h00, ese_o} :
                    (qry_sel_i == isr_pkg::QRY_SRE) ? {8'h00, sre_o} :
                    (qry_sel_i == isr_pkg::QRY_QEV) ? qev_latch :
                    (qry_sel_i == isr_pkg::QRY_QEN) ? qen_o :
                    (qry_sel_i == isr_pkg::QRY_PSC) ? {15'h0000, psc} :
                    isr_pkg::RST_RDATA;

    // status byte, read answer and queue strobe come from flops
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            stb_o      <= isr_pkg::RST_MASK8;
            srq_o      <= 1'b0;
            rd_valid_o <= 1'b0;
            rd_data_o  <= isr_pkg::RST_RDATA;
            err_push_o <= 1'b0;
        end else begin
            stb_o      <= stb_comb;
            srq_o      <= rqs;
            rd_valid_o <= qry_i;
            rd_data_o  <= qry_i ? rd_mux : rd_data_o;
            err_push_o <= err_any;
        end
    end

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_b_i);

    AST_LATCH_HOLD: assert property (!esr_clr |=> (esr_latch & $past(esr_latch)) == $past(esr_latch))
        else $error("event bit dropped without clear");
    AST_READ_VALUE: assert property (qry_i && qry_sel_i == isr_pkg::QRY_ESR
        |=> rd_valid_o && rd_data_o == {8'h00, $past(esr_latch)})
        else $error("event read value wrong");
    AST_MASK_KEEP: assert property ((qry_i || cls_i) && !ese_wr_i && !power_up |=> ese_o == $past(ese_o))
        else $error("enable mask changed by read or clear");
    AST_QSUM: assert property (##1 stb_o[isr_pkg::STB_QSUM] == $past(|(qev_latch & qen_o)))
        else $error("questionable summary wrong");
    AST_MAV: assert property (##1 stb_o[isr_pkg::STB_MAV] == $past(msg_avail_i))
        else $error("message available wrong");
    AST_CLS: assert property (cls_i && esr_set == 8'h00 && qev_set == 16'h0000
        |=> esr_latch == 8'h00 && qev_latch == 16'h0000 ##1 stb_o[5] == 1'b0 && stb_o[3] == 1'b0)
        else $error("clear status left bits set");
    AST_RQS: assert property (##1 stb_o[isr_pkg::STB_RQS] == |(stb_o[5:0] & $past(sre_o[5:0])))
        else $error("service request mismatch");
    // release can land on the very edge that starts an attempt, so the sampled reset level qualifies these
    AST_PSC_CLR: assert property (rst_b_i && power_up && nv_psc_i |=> sre_o == 8'h00 && ese_o == 8'h00)
        else $error("mask not cleared at power-up");
    AST_PSC_KEEP: assert property (rst_b_i && power_up && !nv_psc_i |=> sre_o == $past(nv_sre_i))
        else $error("mask not kept at power-up");
    AST_PON: assert property (rst_b_i && power_up |=> esr_latch[isr_pkg::ESR_PON] && !power_up)
        else $error("power on bit not set");
    AST_UNUSED: assert property (stb_o[2:0] == 3'h0 && !stb_o[7] && !esr_latch[1] && !esr_latch[6])
        else $error("unused bit set");
    AST_OVL_NOQ: assert property (ovl_any && !err_any |=> !err_push_o && esr_latch[isr_pkg::ESR_DDE])
        else $error("overload handled wrong");
    AST_ERR_BIT: assert property (err_push_o |-> esr_latch[5:2] != 4'h0)
        else $error("queued error without event bit");

    COV_CLS: cover property (cls_i && esr_latch != 8'h00);
    COV_SRQ: cover property ($rose(srq_o));
    COV_RD_CLR: cover property (qry_i && qry_sel_i == isr_pkg::QRY_QEV && qev_latch != 16'h0000);
    COV_SET_CLR: cover property (esr_clr && esr_set != 8'h00);

endmodule : isr_top

// file: logic/isr_pkg.sv
// shared constants and types for the instrument status reporting block
package isr_pkg;

    // widths of the three register groups
    localparam int STB_W = 8;   // status summary byte
    localparam int ESR_W = 8;   // standard event latch
    localparam int QEV_W = 16;  // questionable-data latch

    // status summary byte bit positions
    localparam int STB_QSUM = 3;  // questionable-data summary, weight 8
    localparam int STB_MAV  = 4;  // message available, weight 16
    localparam int STB_ESUM = 5;  // standard event summary, weight 32
    localparam int STB_RQS  = 6;  // request service, weight 64

    // standard event latch bit positions
    localparam int ESR_OPC  = 0;  // operation complete
    localparam int ESR_UNU1 = 1;  // unused, reads zero
    localparam int ESR_QYE  = 2;  // query error
    localparam int ESR_DDE  = 3;  // device error
    localparam int ESR_EXE  = 4;  // execution error
    localparam int ESR_CME  = 5;  // command error
    localparam int ESR_UNU6 = 6;  // unused, reads zero
    localparam int ESR_PON  = 7;  // power on

    // questionable-data latch bit positions
    localparam int QEV_VOLT = 0;   // voltage overload
    localparam int QEV_CURR = 1;   // current overload
    localparam int QEV_OHM  = 9;   // ohms overload
    localparam int QEV_LLO  = 11;  // limit failed low
    localparam int QEV_LHI  = 12;  // limit failed high

    // values after reset
    localparam logic [7:0]  RST_MASK8  = 8'h00;
    localparam logic [15:0] RST_MASK16 = 16'h0000;
    localparam logic [15:0] RST_RDATA  = 16'h0000;

    // query selector codes on the command port
    localparam logic [2:0] QRY_STB = 3'h0;  // status byte read, also serial poll
    localparam logic [2:0] QRY_ESR = 3'h1;  // standard event latch, clears it
    localparam logic [2:0] QRY_ESE = 3'h2;  // standard event enable mask
    localparam logic [2:0] QRY_SRE = 3'h3;  // status byte enable mask
    localparam logic [2:0] QRY_QEV = 3'h4;  // questionable latch, clears it
    localparam logic [2:0] QRY_QEN = 3'h5;  // questionable enable mask
    localparam logic [2:0] QRY_PSC = 3'h6;  // power-on-clear flag

    // power-up sequencer states
    typedef enum logic {
        PWR_LOAD,
        PWR_RUN
    } isr_pwr_e;

endpackage : isr_pkg

// file: logic/isr_evt_latch.sv
// sticky event latch with enable mask and summary output
module isr_evt_latch #(
    parameter int WIDTH = 8
) (
    input  wire logic             core_clk_i,
    input  wire logic             rst_b_i,
    input  wire logic [WIDTH-1:0] set_i,      // condition pulses
    input  wire logic             clr_i,      // clear whole latch
    input  wire logic [WIDTH-1:0] mask_i,     // enable mask
    output logic      [WIDTH-1:0] latch_o,    // latched event bits
    output logic                  summary_o   // or of enabled set bits
);

    logic [WIDTH-1:0] next_latch;  // next latch contents

    // set beats clear so a same-cycle event is never lost
    assign next_latch = (clr_i ? '0 : latch_o) | set_i;

    // once set a bit ignores its condition until cleared
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            latch_o <= '0;
        end else begin
            latch_o <= next_latch;
        end
    end

    assign summary_o = |(latch_o & mask_i);

endmodule : isr_evt_latch

// file: logic/isr_mask_reg.sv
// enable mask register with power-up restore
module isr_mask_reg #(
    parameter int WIDTH = 8
) (
    input  wire logic             core_clk_i,
    input  wire logic             rst_b_i,
    input  wire logic             restore_i,    // power-up load
    input  wire logic [WIDTH-1:0] restore_val_i,
    input  wire logic             wr_i,         // controller write
    input  wire logic [WIDTH-1:0] wr_data_i,
    input  wire logic             preset_i,     // clear to zero
    output logic      [WIDTH-1:0] mask_o
);

    logic [WIDTH-1:0] next_mask;  // next mask value

    // restore first, then write, then preset; reads never touch it
    assign next_mask = restore_i ? restore_val_i :
                       wr_i      ? wr_data_i     :
                       preset_i  ? '0            : mask_o;

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            mask_o <= '0;
        end else begin
            mask_o <= next_mask;
        end
    end

endmodule : isr_mask_reg

// file: verif/isr_ctrl_model.sv
// remote controller model: issues status commands and queries
module isr_ctrl_model (
    input  wire logic        core_clk_i,
    input  wire logic        rd_valid_i,  // answer strobe
    input  wire logic [15:0] rd_data_i,   // answer value
    output logic      [5:0]  cmd_o,       // ese, sre, qen, psc, preset, clear
    output logic      [15:0] wdata_o,     // shared write value
    output logic             qry_o,       // query strobe
    output logic      [2:0]  qry_sel_o    // queried register
);
    timeunit 1ns;
    timeprecision 1ps;

    // idle bus at time zero
    initial begin
        cmd_o     = 6'h00;
        wdata_o   = 16'h0000;
        qry_o     = 1'b0;
        qry_sel_o = 3'h0;
    end

    // one command, value held over the taking edge
    task automatic issue(input int idx, input logic [15:0] val);
        @(posedge core_clk_i);
        cmd_o      <= 6'h01 << idx;
        wdata_o    <= val;
        @(posedge core_clk_i);
        cmd_o      <= 6'h00;
        // released bus does not keep the old value
        wdata_o    <= ~val;
        // let the taking edge settle before the caller looks
        #1;
    endtask : issue

    // one query, answer taken one cycle after the strobe
    task automatic ask(input logic [2:0] sel, output logic [15:0] val, output logic vld);
        @(posedge core_clk_i);
        qry_o     <= 1'b1;
        qry_sel_o <= sel;
        @(posedge core_clk_i);
        qry_o     <= 1'b0;
        qry_sel_o <= ~sel;
        #1;
        vld = rd_valid_i;
        val = rd_data_i;
    endtask : ask
endmodule : isr_ctrl_model

// file: verif/isr_top_bench.sv
// self-checking bench for the status aggregation block
module isr_top_bench;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk = 1'b0;        // 25 MHz core clock
    logic        rst_b = 1'b0;      // power-up reset, active low
    logic        nv_psc = 1'b0;     // stored image seen at power-up
    logic [7:0]  nv_ese = 8'h00;
    logic [7:0]  nv_sre = 8'h00;
    logic [12:0] cond = 13'h0000;   // condition pulses
    logic        msg_avail = 1'b0;  // output buffer level
    logic [5:0]  cmd;
    logic [15:0] wdata;
    logic        qry;
    logic [2:0]  qsel;
    logic        rd_valid;
    logic [15:0] rd_data;
    logic [7:0]  stb, ese, sre;
    logic [15:0] qen;
    logic        srq, push, psc;
    int          error_cnt = 0;
    int          tests_run = 0;
    int          cycles = 0;

    // per condition: event weight, queue entry, questionable bits
    localparam logic [7:0]  EXP_ESR [13] = '{8'h01, 8'h04, 8'h04, 8'h04, 8'h08, 8'h08, 8'h08,
                                              8'h08, 8'h08, 8'h00, 8'h00, 8'h10, 8'h20};
    localparam logic        EXP_PSH [13] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0,
                                              1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
    localparam logic [15:0] EXP_QEV [13] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
                                              16'h0000, 16'h0001, 16'h0002, 16'h0200, 16'h0800,
                                              16'h1000, 16'h0000, 16'h0000};

    // clock generator
    always #20 clk = ~clk;

    isr_ctrl_model ctrl (.core_clk_i(clk), .rd_valid_i(rd_valid), .rd_data_i(rd_data), .cmd_o(cmd),
                         .wdata_o(wdata), .qry_o(qry), .qry_sel_o(qsel));

    isr_top dut (.core_clk_i(clk), .rst_b_i(rst_b), .nv_psc_i(nv_psc), .nv_ese_i(nv_ese),
        .nv_sre_i(nv_sre), .cls_i(cmd[5]), .ese_wr_i(cmd[0]), .ese_data_i(wdata[7:0]),
        .sre_wr_i(cmd[1]), .sre_data_i(wdata[7:0]), .qen_wr_i(cmd[2]), .qen_data_i(wdata),
        .qen_preset_i(cmd[4]), .psc_wr_i(cmd[3]), .psc_data_i(wdata[0]), .qry_i(qry),
        .qry_sel_i(qsel), .opc_done_i(cond[0]), .qerr_empty_i(cond[1]), .qerr_unread_i(cond[2]),
        .qerr_full_i(cond[3]), .selftest_fail_i(cond[4]), .cal_fail_i(cond[5]),
        .ovl_volt_i(cond[6]), .ovl_curr_i(cond[7]), .ovl_ohm_i(cond[8]), .limit_lo_i(cond[9]),
        .limit_hi_i(cond[10]), .exec_err_i(cond[11]), .cmd_err_i(cond[12]),
        .msg_avail_i(msg_avail), .rd_valid_o(rd_valid), .rd_data_o(rd_data), .stb_o(stb),
        .srq_o(srq), .err_push_o(push), .ese_o(ese), .sre_o(sre), .qen_o(qen), .psc_o(psc));

    // verdict and end of run
    task automatic end_sim();
        if (error_cnt == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_sim

    // hang guard, far above the few hundred cycles needed
    always @(posedge clk) begin
        cycles++;
        if (cycles == 4000) begin
            error_cnt++;
            end_sim();
        end
    end

    // register value compare
    task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp16

    // single flag compare
    task automatic cmp_bit(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected flag at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp_bit

    // query and judge the answer
    task automatic rd(input logic [2:0] sel, input logic [15:0] exp);
        logic [15:0] v;
        logic        vld;
        ctrl.ask(sel, v, vld);
        cmp_bit(vld, 1'b1);
        cmp16(v, exp);
    endtask : rd

    // status byte one cycle on, service request mirrors bit 6
    task automatic stb_chk(input logic [7:0] exp);
        @(posedge clk);
        #1;
        cmp16({8'h00, stb}, {8'h00, exp});
        cmp_bit(srq, exp[6]);
    endtask : stb_chk

    // one condition pulse; queue entry seen right after the latch edge
    task automatic evt(input int i, output logic pushed);
        @(posedge clk);
        cond <= 13'h0001 << i;
        @(posedge clk);
        cond <= 13'h0000;
        #1;
        pushed = push;
    endtask : evt

    // power cycle with a given stored image
    task automatic power_up(input logic p, input logic [7:0] e, input logic [7:0] s);
        @(posedge clk);
        rst_b  <= 1'b0;
        nv_psc <= p;
        nv_ese <= e;
        nv_sre <= s;
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        // load cycle passes before any request
        repeat (2) @(posedge clk);
        #1;
    endtask : power_up

    // flag clear at power-up keeps masks; power bit reported once
    task automatic t_keep();
        power_up(1'b0, 8'h24, 8'h28);
        cmp16({8'h00, sre}, 16'h0028);
        cmp16({8'h00, ese}, 16'h0024);
        cmp_bit(psc, 1'b0);
        rd(isr_pkg::QRY_ESE, 16'h0024);
        rd(isr_pkg::QRY_SRE, 16'h0028);
        rd(isr_pkg::QRY_PSC, 16'h0000);
        rd(isr_pkg::QRY_ESR, 16'h0080);
        rd(isr_pkg::QRY_ESR, 16'h0000);
        rd(3'h7, 16'h0000);
    endtask : t_keep

    // flag set clears masks; service request follows the mask
    task automatic t_clear_pwr();
        power_up(1'b1, 8'hff, 8'hff);
        cmp16({8'h00, sre}, 16'h0000);
        cmp_bit(psc, 1'b1);
        ctrl.issue(0, 16'h0080);
        stb_chk(8'h20);
        ctrl.issue(1, 16'h0020);
        stb_chk(8'h60);
        ctrl.issue(1, 16'h0000);
        stb_chk(8'h20);
        rd(isr_pkg::QRY_SRE, 16'h0000);
        rd(isr_pkg::QRY_ESR, 16'h0080);
        stb_chk(8'h00);
    endtask : t_clear_pwr

    // every condition source, every mask enabled
    task automatic t_events();
        logic       p;
        logic [7:0] s;
        ctrl.issue(0, 16'h00ff);
        ctrl.issue(1, 16'h00ff);
        ctrl.issue(2, 16'hffff);
        for (int i = 0; i < 13; i++) begin
            evt(i, p);
            cmp_bit(p, EXP_PSH[i]);
            s = ((EXP_ESR[i] != 8'h00) ? 8'h20 : 8'h00) | ((EXP_QEV[i] != 16'h0000) ? 8'h08 : 8'h00);
            stb_chk((s != 8'h00) ? (s | 8'h40) : 8'h00);
            rd(isr_pkg::QRY_ESR, {8'h00, EXP_ESR[i]});
            rd(isr_pkg::QRY_QEV, EXP_QEV[i]);
        end
    endtask : t_events

    // sticky bits, own summary clear on read, clear-status
    task automatic t_sticky();
        logic p;
        ctrl.issue(0, 16'h0010);
        ctrl.issue(1, 16'h0028);
        ctrl.issue(2, 16'h0200);
        evt(11, p);
        evt(8, p);
        evt(11, p);
        stb_chk(8'h68);
        rd(isr_pkg::QRY_QEV, 16'h0200);
        stb_chk(8'h60);
        evt(8, p);
        stb_chk(8'h68);
        rd(isr_pkg::QRY_STB, 16'h0068);
        ctrl.issue(5, 16'h0000);
        stb_chk(8'h00);
        rd(isr_pkg::QRY_ESR, 16'h0000);
        rd(isr_pkg::QRY_QEV, 16'h0000);
        rd(isr_pkg::QRY_ESE, 16'h0010);
        rd(isr_pkg::QRY_QEN, 16'h0200);
    endtask : t_sticky

    // message available level, preset and flag write
    task automatic t_msg();
        @(posedge clk);
        msg_avail <= 1'b1;
        stb_chk(8'h10);
        @(posedge clk);
        msg_avail <= 1'b0;
        stb_chk(8'h00);
        ctrl.issue(4, 16'h0000);
        cmp16(qen, 16'h0000);
        // flag is 1 from the last power cycle, so writing 0 shows a change
        ctrl.issue(3, 16'h0000);
        cmp_bit(psc, 1'b0);
    endtask : t_msg

    // main sequence
    initial begin
        t_keep();
        t_clear_pwr();
        t_events();
        t_sticky();
        t_msg();
        end_sim();
    end
endmodule : isr_top_bench
